// ### design/lcd_pkg.sv
package lcd_pkg;
  // ==========================================================
  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int CLK_HZ = 250000000;
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 200;
  localparam int T_HOLD_NS = 10;
  localparam int T_CYCLE_NS = 1000;
  localparam int OSC_HZ = 18000;
  localparam int EXT_TICK_HZ = 2000;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CYCLE_CYC = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC = CYCLE_CYC - SETUP_CYC - PULSE_CYC - HOLD_CYC;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int EXT_HALF = CLK_HZ / (2 * EXT_TICK_HZ);
  localparam int BUSY_CYC = 4;
  // ==========================================================
  // Display geometry.
  localparam int DATA_W = 8;
  localparam int SEG_N = 61;
  localparam int COM_N = 16;
  localparam int COLS = 80;
  localparam int RAM_BITS = 2560;
  localparam int RAM_BYTES = RAM_BITS / DATA_W;
  // ==========================================================
  // Instruction codes and status fields.
  localparam logic [7:0] CMD_ONOFF = 8'hae;
  localparam logic [7:0] CMD_ONOFF_MASK = 8'hfe;
  localparam logic [7:0] CMD_START = 8'hc0;
  localparam logic [7:0] CMD_START_MASK = 8'he0;
  localparam logic [7:0] CMD_PAGE = 8'hb8;
  localparam logic [7:0] CMD_PAGE_MASK = 8'hfc;
  localparam logic [7:0] CMD_RESET = 8'he2;
  localparam int COL_SET_BIT = 7;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_OFF_BIT = 5;
  // ==========================================================
  // Controller register map.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam int CMD_DIS_BIT = 8;
  localparam int CMD_READ_BIT = 9;
  localparam int CFG_STYLE_BIT = 0;
  localparam int CFG_MASTER_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RD_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    LCD_IDLE, LCD_SETUP, LCD_STROBE, LCD_HOLD, LCD_RECOVER
  } lcd_host_state_type;
endpackage : lcd_pkg

// ### design/lcd_port_if.sv
`timescale 1ns/1ps
interface lcd_port_if;
  logic [7:0] hostData;
  logic hostDataOe;
  logic [7:0] devData;
  logic devDataOe;
  logic [7:0] hostBusLines;
  logic dataInstrSelect;
  logic chipSelN;
  logic enRdStrobe;
  logic rwWrStrobe;
  logic initAndBusStylePin;
  logic masterSel;
  logic externalDisplayTick;
  logic acPhaseOut;
  logic acPhaseOe;
  logic acPhaseExt;
  logic acPhaseSignal;
  // ==========================================================
  // Wire levels; an undriven bus floats high.
  assign hostBusLines = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);
  assign acPhaseSignal = acPhaseOe ? acPhaseOut : acPhaseExt;
  modport dev (
    input hostBusLines, dataInstrSelect, chipSelN, enRdStrobe, rwWrStrobe,
    input initAndBusStylePin, masterSel, externalDisplayTick, acPhaseSignal,
    output devData, devDataOe, acPhaseOut, acPhaseOe
  );
  modport host (
    input hostBusLines,
    output hostData, hostDataOe, dataInstrSelect, chipSelN, enRdStrobe,
    output rwWrStrobe, initAndBusStylePin, masterSel, externalDisplayTick
  );
endinterface : lcd_port_if

// ### design/lcd_dev_port.sv
`timescale 1ns/1ps
// What this block does
// R1 - Select high means data, low instruction.
// R2 - Style pin resets; high 68, low 80.
// R3 - Respond only while chip select low.
// R4 - 68 mode: enable qualifies reads and writes.
// R5 - 68 mode: direction high reads, low writes.
// R6 - 80 mode: low read strobe drives data.
// R7 - 80 mode: capture on write strobe rise.
// R8 - One byte per access, eight bits.
// R9 - Frame phase pin: master drives, slave follows.
// R10 - Master/slave chosen by select input.
// R11 - External tick or internal oscillator clock.
// R12 - 2560-bit display RAM holds written data.
// R13 - 61 segment and 16 common outputs.
// R14 - Status byte top bit is busy.
// R15 - Data bus released unless reading.
module lcd_dev_port #(
  parameter bit EXT_CLOCK_MODEL = 1'b1,
  parameter int OSC_DIV = lcd_pkg::OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rst,
  lcd_port_if.dev port,
  output logic [lcd_pkg::SEG_N-1:0] segmentDriveOutputs,
  output logic [lcd_pkg::COM_N-1:0] commonDriveOutputs
);
  localparam int DW = lcd_pkg::DATA_W;

  function automatic logic [8:0] ramIndex(input logic [1:0] pg, input logic [6:0] col);
    ramIndex = 9'(int'(pg) * lcd_pkg::COLS + int'(col));
  endfunction : ramIndex

  function automatic logic [6:0] nextCol(input logic [6:0] col);
    nextCol = (int'(col) == lcd_pkg::COLS - 1) ? 7'h00 : 7'(col + 7'h01);
  endfunction : nextCol

  // ==========================================================
  // Pin samples and style capture.
  logic armR;
  logic initPrevR;
  logic styleR;
  logic csPrevR;
  logic enPrevR;
  logic rwPrevR;
  logic disPrevR;
  logic [DW-1:0] dataPrevR;
  logic tickS1R;
  logic tickS2R;
  logic tickPrevR;
  logic phS1R;
  logic phS2R;
  logic phPrevR;
  logic devReset;

  assign devReset = rst | ~armR | (port.initAndBusStylePin != initPrevR); // R2

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armR <= 1'b0;
      initPrevR <= 1'b1;
      styleR <= 1'b1;
    end else begin
      armR <= 1'b1;
      initPrevR <= port.initAndBusStylePin;
      if (devReset) begin
        styleR <= port.initAndBusStylePin; // R2
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csPrevR <= 1'b1;
      enPrevR <= 1'b0;
      rwPrevR <= 1'b1;
      disPrevR <= 1'b0;
      dataPrevR <= 8'h00;
      tickS1R <= 1'b0;
      tickS2R <= 1'b0;
      tickPrevR <= 1'b0;
      phS1R <= 1'b0;
      phS2R <= 1'b0;
      phPrevR <= 1'b0;
    end else begin
      csPrevR <= port.chipSelN;
      enPrevR <= port.enRdStrobe;
      rwPrevR <= port.rwWrStrobe;
      disPrevR <= port.dataInstrSelect;
      dataPrevR <= port.hostBusLines;
      tickS1R <= port.externalDisplayTick;
      tickS2R <= tickS1R;
      tickPrevR <= tickS2R;
      phS1R <= port.acPhaseSignal;
      phS2R <= phS1R;
      phPrevR <= phS2R;
    end
  end

  // ==========================================================
  // Bus decode.
  logic readActive;
  logic write68;
  logic write80;
  logic writeTake;
  logic readDone;

  assign readActive = ~port.chipSelN & (styleR ? (port.enRdStrobe & port.rwWrStrobe) // R3 R4 R5
                                                : ~port.enRdStrobe); // R6
  assign write68 = enPrevR & ~port.enRdStrobe & ~rwPrevR; // R4 R5
  assign write80 = ~rwPrevR & port.rwWrStrobe; // R7
  assign writeTake = ~csPrevR & (styleR ? write68 : write80); // R3
  assign readDone = ~csPrevR & (styleR ? (enPrevR & ~port.enRdStrobe & rwPrevR)
                                       : (~enPrevR & port.enRdStrobe));

  // ==========================================================
  // Display RAM and address state.
  logic [DW-1:0] ram [lcd_pkg::RAM_BYTES]; // R12
  logic [1:0] pageR;
  logic [6:0] colR;
  logic [4:0] startR;
  logic dispOnR;
  logic [2:0] busyR;
  logic [8:0] curIdx;
  logic [DW-1:0] status;
  logic [DW-1:0] readByteR;
  logic isCmdOnOff;
  logic isCmdStart;
  logic isCmdPage;
  logic isCmdReset;

  assign curIdx = ramIndex(pageR, colR);
  assign isCmdOnOff = (dataPrevR & lcd_pkg::CMD_ONOFF_MASK) == lcd_pkg::CMD_ONOFF;
  assign isCmdStart = (dataPrevR & lcd_pkg::CMD_START_MASK) == lcd_pkg::CMD_START;
  assign isCmdPage = (dataPrevR & lcd_pkg::CMD_PAGE_MASK) == lcd_pkg::CMD_PAGE;
  assign isCmdReset = dataPrevR == lcd_pkg::CMD_RESET;

  always_comb begin
    status = 8'h00;
    status[lcd_pkg::ST_BUSY_BIT] = (busyR != 3'h0); // R14
    status[lcd_pkg::ST_OFF_BIT] = ~dispOnR;
  end

  always_ff @(posedge clk_sys) begin
    if (writeTake && disPrevR) begin
      ram[curIdx] <= dataPrevR; // R1 R8 R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (devReset) begin
      pageR <= 2'h3;
      colR <= 7'h00;
      startR <= 5'h00;
      dispOnR <= 1'b0;
      busyR <= 3'h0;
    end else if (writeTake) begin
      busyR <= 3'(lcd_pkg::BUSY_CYC); // R14
      if (disPrevR) begin
        colR <= nextCol(colR); // R1
      end else if (!dataPrevR[lcd_pkg::COL_SET_BIT]) begin
        colR <= dataPrevR[6:0];
      end else if (isCmdOnOff) begin
        dispOnR <= dataPrevR[0];
      end else if (isCmdStart) begin
        startR <= dataPrevR[4:0];
      end else if (isCmdPage) begin
        pageR <= dataPrevR[1:0];
      end else if (isCmdReset) begin
        startR <= 5'h00;
        colR <= 7'h00;
        pageR <= 2'h3;
      end
    end else begin
      if (busyR != 3'h0) begin
        busyR <= busyR - 3'h1;
      end
      if (readDone && disPrevR) begin
        colR <= nextCol(colR);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readByteR <= 8'h00;
    end else begin
      readByteR <= port.dataInstrSelect ? ram[curIdx] : status; // R1 R14
    end
  end

  assign port.devData = readByteR; // R8
  assign port.devDataOe = readActive; // R15

  // ==========================================================
  // Display timing and frame phase.
  logic [13:0] oscCntR;
  logic dispTick;
  logic [3:0] lineR;
  logic acPhaseR;
  logic [4:0] row;
  logic [lcd_pkg::SEG_N-1:0] segNxt;

  assign dispTick = EXT_CLOCK_MODEL ? (tickS2R & ~tickPrevR) // R11
                                    : (int'(oscCntR) == OSC_DIV - 1);
  assign row = 5'(lineR + startR);

  always_ff @(posedge clk_sys) begin
    if (rst || EXT_CLOCK_MODEL || dispTick) begin
      oscCntR <= 14'h0000;
    end else begin
      oscCntR <= oscCntR + 14'h0001; // R11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (devReset) begin
      lineR <= 4'h0;
      acPhaseR <= 1'b0;
    end else if (!port.masterSel && (phS2R != phPrevR)) begin
      lineR <= 4'h0; // R9 R10
      acPhaseR <= phS2R;
    end else if (dispTick) begin
      lineR <= 4'(lineR + 4'h1);
      if (port.masterSel && int'(lineR) == lcd_pkg::COM_N - 1) begin
        acPhaseR <= ~acPhaseR; // R9 R10
      end
    end
  end

  assign port.acPhaseOut = acPhaseR; // R9
  assign port.acPhaseOe = port.masterSel; // R10

  always_comb begin
    segNxt = '0;
    for (int s = 0; s < lcd_pkg::SEG_N; s++) begin
      segNxt[s] = dispOnR & ram[ramIndex(row[4:3], 7'(s))][row[2:0]]; // R13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (devReset) begin
      segmentDriveOutputs <= '0;
      commonDriveOutputs <= '0;
    end else begin
      segmentDriveOutputs <= segNxt; // R13
      commonDriveOutputs <= dispOnR ? (16'h0001 << lineR) : 16'h0000; // R13
    end
  end
endmodule : lcd_dev_port

// ### design/lcd_host_ctrl.sv
`timescale 1ns/1ps
module lcd_host_ctrl #(
  parameter int EXT_HALF = lcd_pkg::EXT_HALF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  lcd_port_if.host port
);
  // ==========================================================
  // Register slave.
  logic awHeldR;
  logic [7:0] awAddrR;
  logic wHeldR;
  logic [31:0] wDataR;
  logic [3:0] wStrbR;
  logic doWrite;
  logic wrMapped;
  logic rdMapped;
  logic launch;
  logic [7:0] cmdByteR;
  logic cmdDisR;
  logic cmdReadR;
  logic styleR;
  logic masterR;
  logic [7:0] rdByteR;
  logic [31:0] statWord;
  lcd_pkg::lcd_host_state_type stR;

  assign awready = ~awHeldR & ~bvalid;
  assign wready = ~wHeldR & ~bvalid;
  assign arready = ~rvalid;
  assign doWrite = awHeldR & wHeldR & ~bvalid;
  assign wrMapped = awAddrR == lcd_pkg::REG_CMD || awAddrR == lcd_pkg::REG_CFG;
  assign rdMapped = araddr == lcd_pkg::REG_CMD || araddr == lcd_pkg::REG_STAT
                    || araddr == lcd_pkg::REG_CFG;
  assign launch = doWrite && awAddrR == lcd_pkg::REG_CMD && stR == lcd_pkg::LCD_IDLE
                  && wStrbR[1:0] == 2'h3;
  assign statWord = {16'h0000, rdByteR, 7'h00, stR != lcd_pkg::LCD_IDLE};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeldR <= 1'b0;
      awAddrR <= 8'h00;
      wHeldR <= 1'b0;
      wDataR <= 32'h00000000;
      wStrbR <= 4'h0;
      bvalid <= 1'b0;
      bresp <= lcd_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeldR <= 1'b1;
        awAddrR <= awaddr;
      end
      if (wvalid && wready) begin
        wHeldR <= 1'b1;
        wDataR <= wdata;
        wStrbR <= wstrb;
      end
      if (doWrite) begin
        awHeldR <= 1'b0;
        wHeldR <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrMapped ? lcd_pkg::RESP_OKAY : lcd_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      styleR <= 1'b1;
      masterR <= 1'b1;
    end else if (doWrite && awAddrR == lcd_pkg::REG_CFG && wStrbR[0]) begin
      styleR <= wDataR[lcd_pkg::CFG_STYLE_BIT];
      masterR <= wDataR[lcd_pkg::CFG_MASTER_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= lcd_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= rdMapped ? lcd_pkg::RESP_OKAY : lcd_pkg::RESP_SLVERR;
      case (araddr)
        lcd_pkg::REG_CMD: rdata <= {22'h000000, cmdReadR, cmdDisR, cmdByteR};
        lcd_pkg::REG_STAT: rdata <= statWord;
        lcd_pkg::REG_CFG: rdata <= {30'h00000000, masterR, styleR};
        default: rdata <= 32'h00000000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Bus cycle engine.
  logic [8:0] cntR;
  logic cntDone;
  logic strobe;

  always_comb begin
    case (stR)
      lcd_pkg::LCD_SETUP: cntDone = int'(cntR) == lcd_pkg::SETUP_CYC - 1;
      lcd_pkg::LCD_STROBE: cntDone = int'(cntR) == lcd_pkg::PULSE_CYC - 1;
      lcd_pkg::LCD_HOLD: cntDone = int'(cntR) == lcd_pkg::HOLD_CYC - 1;
      lcd_pkg::LCD_RECOVER: cntDone = int'(cntR) == lcd_pkg::RECOVER_CYC - 1;
      default: cntDone = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stR <= lcd_pkg::LCD_IDLE;
      cntR <= 9'h000;
      cmdByteR <= 8'h00;
      cmdDisR <= 1'b0;
      cmdReadR <= 1'b0;
      rdByteR <= 8'h00;
    end else begin
      cntR <= cntDone ? 9'h000 : 9'(cntR + 9'h001);
      case (stR)
        lcd_pkg::LCD_IDLE: begin
          cntR <= 9'h000;
          if (launch) begin
            cmdByteR <= wDataR[7:0];
            cmdDisR <= wDataR[lcd_pkg::CMD_DIS_BIT];
            cmdReadR <= wDataR[lcd_pkg::CMD_READ_BIT];
            stR <= lcd_pkg::LCD_SETUP;
          end
        end
        lcd_pkg::LCD_SETUP: if (cntDone) stR <= lcd_pkg::LCD_STROBE;
        lcd_pkg::LCD_STROBE: begin
          if (cntDone) begin
            stR <= lcd_pkg::LCD_HOLD;
            if (cmdReadR) begin
              rdByteR <= port.hostBusLines;
            end
          end
        end
        lcd_pkg::LCD_HOLD: if (cntDone) stR <= lcd_pkg::LCD_RECOVER;
        lcd_pkg::LCD_RECOVER: if (cntDone) stR <= lcd_pkg::LCD_IDLE;
        default: stR <= lcd_pkg::LCD_IDLE;
      endcase
    end
  end

  assign strobe = stR == lcd_pkg::LCD_STROBE;
  assign port.chipSelN = ~(stR == lcd_pkg::LCD_SETUP || strobe || stR == lcd_pkg::LCD_HOLD); // R3
  assign port.dataInstrSelect = cmdDisR; // R1
  assign port.hostData = cmdByteR; // R8
  assign port.hostDataOe = ~port.chipSelN & ~cmdReadR;
  assign port.enRdStrobe = styleR ? strobe : ~(strobe & cmdReadR); // R4 R6
  assign port.rwWrStrobe = styleR ? (cmdReadR | port.chipSelN) : ~(strobe & ~cmdReadR); // R5 R7
  assign port.initAndBusStylePin = styleR;
  assign port.masterSel = masterR;

  // ==========================================================
  // External display tick.
  logic [15:0] tickCntR;
  logic tickR;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tickCntR <= 16'h0000;
      tickR <= 1'b0;
    end else if (int'(tickCntR) == EXT_HALF - 1) begin
      tickCntR <= 16'h0000;
      tickR <= ~tickR;
    end else begin
      tickCntR <= tickCntR + 16'h0001;
    end
  end

  assign port.externalDisplayTick = tickR;
endmodule : lcd_host_ctrl

// ### verif/lcd_port_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker between the host engine and the device.
module lcd_port_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] hostBusLines,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic dataInstrSelect,
  input wire logic chipSelN,
  input wire logic enRdStrobe,
  input wire logic rwWrStrobe,
  input wire logic initAndBusStylePin,
  input wire logic masterSel,
  input wire logic acPhaseOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire logic style68 = initAndBusStylePin;
  wire logic strobeOn = style68 ? enRdStrobe : (!enRdStrobe || !rwWrStrobe);
  wire logic rdOn = style68 ? (enRdStrobe && rwWrStrobe) : !enRdStrobe;
  a_no_contention: assert property (!(devDataOe && hostDataOe))
    else $error("Both ends drive the data bus.");
  a_idle_release: assert property (chipSelN |-> !devDataOe)
    else $error("Device drives the bus while deselected.");
  a_read_drives: assert property (!chipSelN && rdOn |-> devDataOe)
    else $error("Device does not drive the bus during a read.");
  a_write_released: assert property (!chipSelN && !rdOn |-> !devDataOe)
    else $error("Device drives the bus outside a read.");
  a_strobe_in_cs: assert property (strobeOn |-> !chipSelN)
    else $error("Strobe active while chip select is high.");
  a_qual_stable: assert property (strobeOn && $past(strobeOn)
    |-> $stable(dataInstrSelect) && $stable(chipSelN))
    else $error("Select or chip select moved during a strobe.");
  a_wdata_stable: assert property (hostDataOe && strobeOn && $past(strobeOn)
    |-> $stable(hostBusLines))
    else $error("Write byte moved during a strobe.");
  a_cs_held: assert property ($fell(chipSelN) |-> !chipSelN [*8])
    else $error("Chip select released too early.");
  a_cs_window: assert property ($fell(chipSelN) |-> ##[55:60] $rose(chipSelN))
    else $error("Chip select low for a wrong span.");
  a_phase_dir: assert property (!$past(rst, 2) && masterSel == $past(masterSel, 4)
    |-> acPhaseOe == masterSel)
    else $error("Frame phase pin direction does not follow master select.");
  c_write80: cover property (!style68 && $rose(rwWrStrobe) && !chipSelN);
  c_read68: cover property (style68 && rdOn && !chipSelN);
  c_slave: cover property (!masterSel && !acPhaseOe);
endmodule : lcd_port_monitor

// ### verif/tb_lcd_driver_host_port.sv
`timescale 1ns/1ps
module tb_lcd_driver_host_port;
  logic clk_sys, rst;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int error_cnt, compares;
  logic [lcd_pkg::SEG_N-1:0] seg;
  logic [lcd_pkg::COM_N-1:0] com;
  lcd_port_if bus();
  lcd_host_ctrl #(.EXT_HALF(16)) i_lcd_host_ctrl (.clk_sys(clk_sys), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .port(bus));
  lcd_dev_port #(.EXT_CLOCK_MODEL(1'b1), .OSC_DIV(8)) i_lcd_dev_port (.clk_sys(clk_sys),
    .rst(rst), .port(bus), .segmentDriveOutputs(seg), .commonDriveOutputs(com));
  lcd_port_monitor i_lcd_port_monitor (.clk_sys(clk_sys), .rst(rst),
    .hostBusLines(bus.hostBusLines), .hostDataOe(bus.hostDataOe),
    .devDataOe(bus.devDataOe), .dataInstrSelect(bus.dataInstrSelect),
    .chipSelN(bus.chipSelN), .enRdStrobe(bus.enRdStrobe), .rwWrStrobe(bus.rwWrStrobe),
    .initAndBusStylePin(bus.initAndBusStylePin), .masterSel(bus.masterSel),
    .acPhaseOe(bus.acPhaseOe));
  // ==========================================================
  // Reporting.
  task automatic close_out();
    $display("Counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s resp %h exp %h", $time, what, got, exp);
    end
  endtask : chk_resp
  function automatic logic [7:0] exp_status(input bit off);
    return 8'(off) << lcd_pkg::ST_OFF_BIT;
  endfunction : exp_status
  // ==========================================================
  // Register bus master.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_sys);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk_sys);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd
  task automatic lcd_acc(input bit sel, input bit rd, input logic [7:0] b,
                         output logic [7:0] got);
    logic [1:0] r;
    logic [31:0] s;
    int n;
    axi_wr(lcd_pkg::REG_CMD, {22'h0, rd, sel, b}, r);
    n = 0;
    do begin
      axi_rd(lcd_pkg::REG_STAT, s, r);
      n++;
    end while (s[lcd_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 400);
    if (s[lcd_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      error_cnt++;
      $display("BAD t=%0t engine stuck busy", $time);
    end
    got = s[15:8];
  endtask : lcd_acc
  // ==========================================================
  // Clock, watchdog and tests.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    close_out();
  end
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] g, b0, b1, col, pg;
    logic ph;
    int n;
    void'($urandom(32'h16a429a4));
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    bus.acPhaseExt = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    axi_rd(lcd_pkg::REG_STAT, d, r);
    chk_val(32'(d[lcd_pkg::STAT_BUSY_BIT]), 32'h0, "idle after reset");
    axi_wr(8'h0c, $urandom, r);
    chk_resp(r, lcd_pkg::RESP_SLVERR, "unmapped write");
    axi_rd(8'h10, d, r);
    chk_resp(r, lcd_pkg::RESP_SLVERR, "unmapped read");
    chk_val(d, 32'h0, "unmapped data");
    $display("Test registers done");
    for (int s = 1; s >= 0; s--) begin
      axi_wr(lcd_pkg::REG_CFG, {30'h0, 1'b1, 1'(s)}, r);
      chk_resp(r, lcd_pkg::RESP_OKAY, "cfg write");
      lcd_acc(1'b0, 1'b1, 8'h0, g);
      chk_val(g, exp_status(1'b1), "status after style reset");
      lcd_acc(1'b0, 1'b0, 8'haf, g);
      lcd_acc(1'b0, 1'b1, 8'h0, g);
      chk_val(g, exp_status(1'b0), "status display on");
      chk_val(32'($countones(com)), 32'h1, "one common line on");
      for (int i = 0; i < 3; i++) begin
        pg = 8'($urandom % 4);
        col = (i == 0) ? 8'h4f : 8'($urandom % 80);
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        lcd_acc(1'b0, 1'b0, lcd_pkg::CMD_PAGE | pg, g);
        lcd_acc(1'b0, 1'b0, col, g);
        lcd_acc(1'b1, 1'b0, b0, g);
        lcd_acc(1'b1, 1'b0, b1, g);
        lcd_acc(1'b0, 1'b0, col, g);
        lcd_acc(1'b1, 1'b1, 8'h0, g);
        chk_val(g, b0, "first byte");
        lcd_acc(1'b1, 1'b1, 8'h0, g);
        chk_val(g, b1, "second byte");
      end
      lcd_acc(1'b0, 1'b0, lcd_pkg::CMD_ONOFF, g);
      lcd_acc(1'b0, 1'b1, 8'h0, g);
      chk_val(g, exp_status(1'b1), "status display off");
      chk_val(32'(com), 32'h0, "commons off");
      chk_val(32'(|seg), 32'h0, "segments off");
      $display("Test style %0d done", s);
    end
    axi_wr(lcd_pkg::REG_CFG, 32'h1, r);
    repeat (8) @(posedge clk_sys);
    bus.acPhaseExt <= 1'b1;
    @(negedge clk_sys);
    chk_val(32'(bus.acPhaseOe), 32'h0, "slave releases phase");
    axi_wr(lcd_pkg::REG_CFG, 32'h3, r);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_val(32'(bus.acPhaseOe), 32'h1, "master drives phase");
    ph = bus.acPhaseSignal;
    n = 0;
    while (bus.acPhaseSignal === ph && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    chk_val(32'(n < 3000), 32'h1, "master phase toggles");
    $display("Test frame phase done");
    close_out();
  end
endmodule : tb_lcd_driver_host_port
